// *** src/hmfc_top.sv ***
`timescale 1ns/1ns
`include "hmfc_params.svh"
// Notes on behaviour
// - low level bits 15:8, 64-byte units
// - below low level: send zero-time pause
// - zero pause only after high pause, enabled
// - low level releases hardwired port throttle
// - hold code bits 7:4, half duplex only
// - code table per speed, slow adds 2.2us
// - hold time counts from high level reached
// - group frames jammed in half duplex
// - all-station frames jammed in half duplex
// - own-address frames jammed in half duplex
// - every-frame mode jams on next preamble
// - every-frame full duplex requests pause frame
// - every-frame mode overrides bits 3:1
// - high level bits 23:16 triggers flow control
// - nothing sent while transmitter disabled
module hmfc_top #(
	parameter int LEVEL_W        = 14,
	parameter int JAM_UNIT_CYC   = `HMFC_JAM_UNIT_NS / `HMFC_CLK_NS,
	parameter int SLOW_EXTRA_CYC = `HMFC_SLOW_EXTRA_NS / `HMFC_CLK_NS
) (
	input  wire logic                       clk_i,
	input  wire logic                       sys_rst_i,
	input  wire logic                       hsel_i,
	input  wire logic [31:0]                haddr_i,
	input  wire logic [1:0]                 htrans_i,
	input  wire logic                       hwrite_i,
	input  wire logic [2:0]                 hsize_i,
	input  wire logic [31:0]                hwdata_i,
	input  wire logic                       hready_i,
	output logic      [31:0]                hrdata_o,
	output logic                            hreadyout_o,
	output logic                            hresp_o,
	input  wire logic [LEVEL_W-1:0]         rx_level_i,
	input  wire hmfc_pkg::hmfc_rx_event_type rx_event_i,
	input  wire logic                       tx_enable_i,
	input  wire logic                       full_duplex_i,
	input  wire logic                       speed_100_i,
	input  wire logic                       hardwired_throttle_enable_i,
	input  wire logic                       pause_ack_i,
	output hmfc_pkg::hmfc_pause_type        pause_o,
	output logic                            jam_o,
	output logic                            port_zero_hold_o
);

	localparam int CNT_W = 17;

	// ****************************************************************
	// elaboration checks
	// ****************************************************************
	generate
		if (LEVEL_W < 8 + `HMFC_LEVEL_SHIFT) begin : g_bad_level
			$error("LEVEL_W too narrow for the threshold range");
		end
		if (JAM_UNIT_CYC < 1 || JAM_UNIT_CYC * 120 + SLOW_EXTRA_CYC >= 2 ** CNT_W) begin : g_bad_t
			$error("jam timing does not fit the timer");
		end
	endgenerate

	// ****************************************************************
	// functions
	// ****************************************************************
	// threshold field to byte count
	function automatic logic [LEVEL_W-1:0] to_bytes(input logic [7:0] lvl);
		to_bytes = LEVEL_W'({lvl, 6'h00});
	endfunction

	// register select: 0 none, 1 config, 2 status
	function automatic logic [1:0] reg_sel(input logic [31:0] addr);
		reg_sel = 2'h0;
		if (addr[31:8] == 24'h00_0000 && addr[7:0] == `HMFC_CFG_ADDR) begin
			reg_sel = 2'h1;
		end else if (addr[31:8] == 24'h00_0000 && addr[7:0] == `HMFC_STAT_ADDR) begin
			reg_sel = 2'h2;
		end
	endfunction

	// hold time in cycles: 5us units, then column offset for 10 Mb/s
	function automatic logic [CNT_W-1:0] jam_cycles(input logic [3:0] code,
	                                                input logic       fast);
		logic [7:0] units;
		units = 8'h00;
		unique case (code)
			4'h0:    units = 8'h01;
			4'h1:    units = 8'h02;
			4'h2:    units = 8'h03;
			4'h3:    units = 8'h05;
			4'h4:    units = 8'h0A;
			default: units = (8'(code) - 8'h03) * 8'h0A;
		endcase
		jam_cycles = CNT_W'(units * JAM_UNIT_CYC) + (fast ? '0 : CNT_W'(SLOW_EXTRA_CYC));
	endfunction

	// ****************************************************************
	// declarations
	// ****************************************************************
	hmfc_pkg::hmfc_cfg_type   cfg_r;
	hmfc_pkg::hmfc_cfg_type   cfg_nxt;
	hmfc_pkg::hmfc_state_type state_r;
	hmfc_pkg::hmfc_state_type state_nxt;
	hmfc_pkg::hmfc_pause_type pause_r;
	hmfc_pkg::hmfc_pause_type pause_nxt;
	logic                     cfg_wr_r;
	logic                     cfg_wr_nxt;
	logic [31:0]              rdata_r;
	logic [31:0]              rdata_nxt;
	logic                     hreadyout_r;
	logic                     hresp_r;
	logic                     high_r;
	logic                     jam_r;
	logic                     jam_nxt;
	logic                     hold_r;
	logic                     hold_nxt;
	logic                     bus_req;
	logic                     high_hit;
	logic                     below_low;
	logic                     reach_evt;
	logic                     fd_auto;
	logic                     hd_on;
	logic                     match;
	logic                     tmr_start;
	logic                     tmr_run;
	logic                     tmr_last;
	logic [CNT_W-1:0]         tmr_load;
	logic [31:0]              status;

	// ****************************************************************
	// ahb-lite slave, zero wait states
	// ****************************************************************
	assign bus_req = hsel_i & hready_i & htrans_i[1];

	always_comb begin
		status = 32'h0000_0000;
		status[`HMFC_ST_HIGH_BIT] = high_hit;
		status[`HMFC_ST_LOW_BIT]  = below_low;
		status[`HMFC_ST_JAM_BIT]  = jam_r;
		status[`HMFC_ST_TMR_BIT]  = tmr_run;
		status[`HMFC_ST_FSM_LSB +: 2] = state_r;
		status[`HMFC_ST_HOLD_BIT] = hold_r;
	end

	// a read right behind a write sees the new word, not the stale one
	always_comb begin
		cfg_nxt    = cfg_r;
		cfg_wr_nxt = bus_req & hwrite_i & (reg_sel(haddr_i) == 2'h1);
		rdata_nxt  = 32'h0000_0000;
		if (cfg_wr_r) begin
			cfg_nxt = hmfc_pkg::hmfc_cfg_type'(hwdata_i & `HMFC_CFG_WMASK);
		end
		if (bus_req && !hwrite_i) begin
			unique case (reg_sel(haddr_i))
				2'h1:    rdata_nxt = cfg_nxt;
				2'h2:    rdata_nxt = status;
				default: rdata_nxt = 32'h0000_0000; // unmapped reads zero
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cfg_r       <= hmfc_pkg::hmfc_cfg_type'(`HMFC_CFG_RESET);
			cfg_wr_r    <= 1'b0;
			rdata_r     <= 32'h0000_0000;
			hreadyout_r <= 1'b1;
			hresp_r     <= 1'b0;
		end else begin
			cfg_r       <= cfg_nxt;
			cfg_wr_r    <= cfg_wr_nxt;
			rdata_r     <= rdata_nxt;
			hreadyout_r <= 1'b1;
			hresp_r     <= 1'b0;
		end
	end

	// ****************************************************************
	// level compare
	// ****************************************************************
	// software keeps low under high; crossed levels only chatter
	assign high_hit  = (rx_level_i >= to_bytes(cfg_r.high_water_level));
	assign below_low = (rx_level_i < to_bytes(cfg_r.low_water_level));
	assign reach_evt = high_hit & ~high_r;
	assign fd_auto   = full_duplex_i & cfg_r.throttle_on_every_frame & tx_enable_i;
	assign hd_on     = ~full_duplex_i & tx_enable_i;

	// ****************************************************************
	// full duplex pause sequencer
	// ****************************************************************
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			hmfc_pkg::HMFC_IDLE: begin
				if (fd_auto && reach_evt) begin
					state_nxt = hmfc_pkg::HMFC_SEND_HI;
				end
			end
			hmfc_pkg::HMFC_SEND_HI: begin
				if (!fd_auto) begin
					state_nxt = hmfc_pkg::HMFC_IDLE;
				end else if (pause_ack_i) begin
					state_nxt = hmfc_pkg::HMFC_WAIT_LO;
				end
			end
			hmfc_pkg::HMFC_WAIT_LO: begin
				if (!(full_duplex_i && cfg_r.throttle_on_every_frame)) begin
					state_nxt = hmfc_pkg::HMFC_IDLE;
				end else if (below_low && tx_enable_i) begin
					state_nxt = hmfc_pkg::HMFC_SEND_LO;
				end
			end
			hmfc_pkg::HMFC_SEND_LO: begin
				if (!fd_auto) begin
					state_nxt = hmfc_pkg::HMFC_WAIT_LO;
				end else if (pause_ack_i) begin
					state_nxt = hmfc_pkg::HMFC_IDLE;
				end
			end
		endcase
		pause_nxt.req  = (state_nxt == hmfc_pkg::HMFC_SEND_HI) |
		                 (state_nxt == hmfc_pkg::HMFC_SEND_LO);
		pause_nxt.zero = (state_nxt == hmfc_pkg::HMFC_SEND_LO);
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_r <= hmfc_pkg::HMFC_IDLE;
			pause_r <= '0;
		end else begin
			state_r <= state_nxt;
			pause_r <= pause_nxt;
		end
	end

	// ****************************************************************
	// half duplex backpressure
	// ****************************************************************
	// every-frame mode needs no address decode, so it keys on preamble
	assign match = cfg_r.throttle_on_every_frame ? rx_event_i.preamble :
	               ((cfg_r.throttle_on_group_frames & rx_event_i.group) |
	                (cfg_r.throttle_on_all_station_frames & rx_event_i.all_station) |
	                (cfg_r.throttle_on_own_address & rx_event_i.own_addr));

	// window opens at the level crossing, not at first jam
	assign tmr_start = ~full_duplex_i & (reach_evt | (high_hit & ~tmr_run & match));
	assign tmr_load  = jam_cycles(cfg_r.jam_hold_code, speed_100_i);

	hmfc_jam_timer #(
		.CNT_W (CNT_W)
	) u_timer (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.start_i   (tmr_start),
		.clear_i   (full_duplex_i),
		.load_i    (tmr_load),
		.running_o (tmr_run),
		.last_o    (tmr_last)
	);

	always_comb begin
		jam_nxt  = hd_on & (tmr_start | (tmr_run & ~tmr_last)) & (jam_r | match);
		hold_nxt = hardwired_throttle_enable_i & (high_hit | (hold_r & ~below_low));
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			high_r <= 1'b0;
			jam_r  <= 1'b0;
			hold_r <= 1'b0;
		end else begin
			high_r <= high_hit;
			jam_r  <= jam_nxt;
			hold_r <= hold_nxt;
		end
	end

	assign hrdata_o         = rdata_r;
	assign hreadyout_o      = hreadyout_r;
	assign hresp_o          = hresp_r;
	assign pause_o          = pause_r;
	assign jam_o            = jam_r;
	assign port_zero_hold_o = hold_r;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_hi_accepted;
		pause_r.req && !pause_r.zero && pause_ack_i && fd_auto;
	endsequence

	property p_hi_then_wait;
		s_hi_accepted |=> (state_r == hmfc_pkg::HMFC_WAIT_LO) && !pause_r.req;
	endproperty
	a_hi_then_wait: assert property (p_hi_then_wait) else $error("no wait after pause");

	property p_zero_after_hi;
		(pause_r.req && pause_r.zero) |-> $past(pause_r.zero || state_r == hmfc_pkg::HMFC_WAIT_LO);
	endproperty
	a_zero_after_hi: assert property (p_zero_after_hi) else $error("zero pause unearned");

	property p_low_sends_zero;
		(state_r == hmfc_pkg::HMFC_WAIT_LO && below_low && fd_auto)
			|=> pause_r.req && pause_r.zero;
	endproperty
	a_low_sends_zero: assert property (p_low_sends_zero) else $error("zero pause missing");

	property p_reach_pauses;
		(state_r == hmfc_pkg::HMFC_IDLE && reach_evt && fd_auto) |=> pause_r.req && !pause_r.zero;
	endproperty
	a_reach_pauses: assert property (p_reach_pauses) else $error("pause not requested");

	property p_tx_off_quiet;
		!tx_enable_i |=> !pause_r.req && !jam_r;
	endproperty
	a_tx_off_quiet: assert property (p_tx_off_quiet) else $error("sent with tx off");

	property p_fd_no_jam;
		full_duplex_i |=> !jam_r;
	endproperty
	a_fd_no_jam: assert property (p_fd_no_jam) else $error("jam in full duplex");

	property p_reach_starts_timer;
		(reach_evt && !full_duplex_i) |=> tmr_run;
	endproperty
	a_reach_starts_timer: assert property (p_reach_starts_timer) else $error("timer idle");

	property p_preamble_jams;
		(cfg_r.throttle_on_every_frame && rx_event_i.preamble && tmr_run && !tmr_last && hd_on)
			|=> jam_r;
	endproperty
	a_preamble_jams: assert property (p_preamble_jams) else $error("no jam on preamble");

	property p_every_overrides;
		(!jam_r && cfg_r.throttle_on_every_frame && !rx_event_i.preamble) |=> !jam_r;
	endproperty
	a_every_overrides: assert property (p_every_overrides) else $error("jam w/o preamble");

	property p_code0_fast;
		(cfg_r.jam_hold_code == 4'h0 && speed_100_i) |-> (tmr_load == CNT_W'(JAM_UNIT_CYC));
	endproperty
	a_code0_fast: assert property (p_code0_fast) else $error("code 0 length wrong");

	property p_hold_release;
		(hold_r && below_low) |=> !hold_r;
	endproperty
	a_hold_release: assert property (p_hold_release) else $error("hold not released");

endmodule

// *** src/hmfc_params.svh ***
`ifndef HMFC_PARAMS_SVH
`define HMFC_PARAMS_SVH

// ****************************************************************
// register map (byte addresses on the AHB-Lite slave)
// ****************************************************************
`define HMFC_CFG_ADDR      8'hAC
`define HMFC_STAT_ADDR     8'hB0
`define HMFC_CFG_RESET     32'h0000_0000
`define HMFC_CFG_WMASK     32'h00FF_FFFF

// ****************************************************************
// status register bit positions
// ****************************************************************
`define HMFC_ST_HIGH_BIT   0
`define HMFC_ST_LOW_BIT    1
`define HMFC_ST_JAM_BIT    2
`define HMFC_ST_TMR_BIT    3
`define HMFC_ST_FSM_LSB    4
`define HMFC_ST_HOLD_BIT   6

// ****************************************************************
// threshold unit and timing
// ****************************************************************
`define HMFC_LEVEL_SHIFT   6
`define HMFC_CLK_NS        10
`define HMFC_JAM_UNIT_NS   5000
`define HMFC_SLOW_EXTRA_NS 2200

`endif

// *** src/hmfc_pkg.sv ***
package hmfc_pkg;

	// ****************************************************************
	// configuration word layout, msb first
	// ****************************************************************
	typedef struct packed {
		logic [7:0] reserved;
		logic [7:0] high_water_level;
		logic [7:0] low_water_level;
		logic [3:0] jam_hold_code;
		logic       throttle_on_group_frames;
		logic       throttle_on_all_station_frames;
		logic       throttle_on_own_address;
		logic       throttle_on_every_frame;
	} hmfc_cfg_type;

	// one-cycle receive events from the mac front end
	typedef struct packed {
		logic preamble;
		logic group;
		logic all_station;
		logic own_addr;
	} hmfc_rx_event_type;

	// pause request toward the mac transmitter
	typedef struct packed {
		logic req;
		logic zero;
	} hmfc_pause_type;

	typedef enum logic [1:0] {
		HMFC_IDLE    = 2'b00,
		HMFC_SEND_HI = 2'b01,
		HMFC_WAIT_LO = 2'b10,
		HMFC_SEND_LO = 2'b11
	} hmfc_state_type;

endpackage

// *** src/hmfc_jam_timer.sv ***
`timescale 1ns/1ns
// ****************************************************************
// backpressure duration down-counter
// ****************************************************************
module hmfc_jam_timer #(
	parameter int CNT_W = 17
) (
	input  wire logic             clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic             start_i,
	input  wire logic             clear_i,
	input  wire logic [CNT_W-1:0] load_i,
	output logic                  running_o,
	output logic                  last_o
);

	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;

	// clear wins so a duplex change kills the window at once
	always_comb begin
		cnt_nxt = cnt_r;
		if (clear_i) begin
			cnt_nxt = '0;
		end else if (start_i) begin
			cnt_nxt = load_i;
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - CNT_W'(1);
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign running_o = (cnt_r != '0);
	assign last_o    = (cnt_r == CNT_W'(1));

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	property p_timer_load;
		(start_i && !clear_i) |=> (cnt_r == $past(load_i));
	endproperty
	a_timer_load: assert property (p_timer_load) else $error("timer did not load");

	property p_timer_step;
		(running_o && !start_i && !clear_i) |=> (cnt_r == $past(cnt_r) - CNT_W'(1));
	endproperty
	a_timer_step: assert property (p_timer_step) else $error("timer step wrong");

endmodule

// *** verification/hmfc_fabric_model.sv ***
`timescale 1ns/1ns
// ****************************************************************
// far side: transmit path that accepts pause requests
// ****************************************************************
module hmfc_fabric_model (
	input  wire logic                     clk_i,
	input  wire logic                     sys_rst_i,
	input  wire logic                     slow_i,
	input  wire hmfc_pkg::hmfc_pause_type pause_i,
	output logic                          pause_ack_o,
	output logic                          halted_o
);
	int wait_r;

	// a request waits for a free transmit slot; slow mode models a long frame in flight
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wait_r <= 0;
			pause_ack_o <= 1'b0;
			halted_o <= 1'b0;
		end else if (pause_ack_o) begin
			pause_ack_o <= 1'b0;
			wait_r <= 0;
		end else if (pause_i.req && wait_r >= (slow_i ? 6 : 1)) begin
			pause_ack_o <= 1'b1;
			halted_o <= !pause_i.zero;
		end else begin
			wait_r <= pause_i.req ? wait_r + 1 : 0;
		end
	end
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/1ns
`include "hmfc_params.svh"
// ****************************************************************
// self-checking bench for the host flow control block
// ****************************************************************
module testbench;
	localparam int UNIT = 5;
	localparam int EXTRA = 2;
	logic                        clk_i;
	logic                        sys_rst_i;
	logic                        hsel_i;
	logic [31:0]                 haddr_i;
	logic [1:0]                  htrans_i;
	logic                        hwrite_i;
	logic [2:0]                  hsize_i;
	logic [31:0]                 hwdata_i;
	logic [31:0]                 hrdata_o;
	logic                        hreadyout_o;
	logic                        hresp_o;
	logic [13:0]                 rx_level_i;
	hmfc_pkg::hmfc_rx_event_type rx_event_i;
	logic                        tx_enable_i;
	logic                        full_duplex_i;
	logic                        speed_100_i;
	logic                        hardwired_throttle_enable_i;
	logic                        pause_ack_i;
	hmfc_pkg::hmfc_pause_type    pause_o;
	logic                        jam_o;
	logic                        port_zero_hold_o;
	logic                        slow_i;
	logic                        halted_o;
	logic                        rd_pend_r = 1'b0;
	logic                        req_seen_r = 1'b0;
	logic [31:0]                 seed_r = 32'h6EF2;
	logic [31:0]                 w;
	logic [31:0]                 rd_q[$];
	logic                        pause_q[$];
	int                          n_fail = 0;
	int                          tests_run = 0;
	int                          cyc = 0;

	hmfc_top #(.LEVEL_W(14), .JAM_UNIT_CYC(UNIT), .SLOW_EXTRA_CYC(EXTRA)) uut (
		.clk_i, .sys_rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
		.hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .rx_level_i, .rx_event_i,
		.tx_enable_i, .full_duplex_i, .speed_100_i, .hardwired_throttle_enable_i,
		.pause_ack_i, .pause_o, .jam_o, .port_zero_hold_o
	);
	hmfc_fabric_model fabric (
		.clk_i, .sys_rst_i, .slow_i, .pause_i(pause_o), .pause_ack_o(pause_ack_i), .halted_o
	);

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// window length in cycles; units of 5 us shrunk to UNIT cycles for a short run
	function automatic int jam_len(input logic [3:0] c, input logic fast);
		int u;
		u = (c < 3) ? c + 1 : (c == 3) ? 5 : (c - 3) * 10;
		return u * UNIT + (fast ? 0 : EXTRA);
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task final_report;
		$display("comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// one single AHB-Lite transfer; read data is noted for the monitor
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
			input logic [31:0] e);
		@(posedge clk_i);
		hsel_i <= 1'b1;
		haddr_i <= a;
		htrans_i <= 2'b10;
		hwrite_i <= wr;
		if (!wr) rd_q.push_back(e);
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		hsel_i <= 1'b0;
		htrans_i <= 2'b00;
		hwdata_i <= d;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		check(hresp_o, 1'b0);
	endtask

	// high pause, hold at exactly the low level, then zero pause below it
	task automatic pause_round(input logic slow);
		slow_i <= slow;
		seed_r = lfsr(seed_r);
		pause_q.push_back(1'b0);
		@(posedge clk_i) rx_level_i <= 14'd256 + 14'(seed_r[5:0]);
		repeat (20) @(posedge clk_i);
		#1 check(port_zero_hold_o, 1'b1);
		check(halted_o, 1'b1);
		@(posedge clk_i) rx_level_i <= 14'd128;
		repeat (8) @(posedge clk_i);
		#1 check(port_zero_hold_o, 1'b1);
		pause_q.push_back(1'b1);
		@(posedge clk_i) rx_level_i <= 14'd127;
		repeat (20) @(posedge clk_i);
		#1 check(halted_o, 1'b0);
		check(port_zero_hold_o, 1'b0);
		check(pause_q.size(), 0);
	endtask

	// half duplex window: timed from the crossing, event placed midway in long windows
	task automatic jam_run(input int i);
		int         len;
		int         d;
		int         k;
		logic [3:0] ev;
		k = i % 4;
		ev = (k == 0) ? 4'b1000 : 4'(1 << (k - 1));
		len = jam_len(4'(i % 16), i < 16);
		d = (len > 10) ? len / 2 : 1;
		seed_r = lfsr(seed_r);
		ahb(1'b1, `HMFC_CFG_ADDR, {16'h0004, 8'h02, 4'(i % 16), 4'(1 << k)}, 32'h0);
		speed_100_i <= (i < 16);
		@(posedge clk_i) rx_level_i <= 14'd256 + 14'(seed_r[3:0]);
		repeat (d) @(posedge clk_i);
		rx_event_i <= ev;
		#1 check(jam_o, 1'b0);
		@(posedge clk_i) rx_event_i <= '0;
		#1 check(jam_o, 1'b1);
		repeat (len - d - 1) @(posedge clk_i);
		#1 check(jam_o, 1'b1);
		@(posedge clk_i);
		#1 check(jam_o, 1'b0);
		@(posedge clk_i) rx_level_i <= 14'd0;
		repeat (4) @(posedge clk_i);
	endtask

	task automatic try_no_jam(input logic [31:0] cfg, input logic [3:0] ev, input logic fd,
			input logic tx);
		ahb(1'b1, `HMFC_CFG_ADDR, cfg, 32'h0);
		full_duplex_i <= fd;
		tx_enable_i <= tx;
		@(posedge clk_i) rx_level_i <= 14'd300;
		@(posedge clk_i) rx_event_i <= ev;
		@(posedge clk_i) rx_event_i <= '0;
		repeat (3) @(posedge clk_i);
		#1 check(jam_o, 1'b0);
		@(posedge clk_i) rx_level_i <= 14'd0;
		repeat (12) @(posedge clk_i);
	endtask

	// ****************************************************************
	// clock, monitor and hang guard
	// ****************************************************************
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// read data is due in the data phase; every pause request must have been noted
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_fail++;
			final_report();
		end
		if (rd_pend_r) begin
			if (rd_q.size() == 0) check(32'h1, 32'h0);
			else check(hrdata_o, rd_q.pop_front());
		end
		if (pause_o.req && !req_seen_r) begin
			if (pause_q.size() == 0) check(32'h1, 32'h0);
			else check(pause_o.zero, pause_q.pop_front());
		end
		rd_pend_r <= hsel_i && htrans_i[1] && !hwrite_i && hreadyout_o;
		req_seen_r <= pause_o.req;
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		sys_rst_i = 1'b1;
		hsel_i = 1'b0;
		haddr_i = 32'h0;
		htrans_i = 2'b00;
		hwrite_i = 1'b0;
		hsize_i = 3'h2;
		hwdata_i = 32'h0;
		rx_level_i = 14'h0;
		rx_event_i = '0;
		tx_enable_i = 1'b0;
		full_duplex_i = 1'b0;
		speed_100_i = 1'b1;
		hardwired_throttle_enable_i = 1'b0;
		slow_i = 1'b0;
		repeat (12) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		ahb(1'b0, `HMFC_CFG_ADDR, 32'h0, `HMFC_CFG_RESET);
		// high level 0 is met at once, so the reset-time hold window is still open
		ahb(1'b0, `HMFC_STAT_ADDR, 32'h0, 32'h0000_0009);
		seed_r = lfsr(seed_r);
		w = seed_r | 32'hFF00_0000;
		ahb(1'b1, `HMFC_CFG_ADDR, w, 32'h0);
		ahb(1'b1, `HMFC_STAT_ADDR, 32'hFFFF_FFFF, 32'h0);
		ahb(1'b1, 32'h0000_0100, 32'hFFFF_FFFF, 32'h0);
		ahb(1'b0, 32'h0000_0100, 32'h0, 32'h0);
		ahb(1'b0, `HMFC_CFG_ADDR, 32'h0, w & `HMFC_CFG_WMASK);
		ahb(1'b1, `HMFC_CFG_ADDR, 32'h0004_0201, 32'h0);
		tx_enable_i <= 1'b1;
		full_duplex_i <= 1'b1;
		hardwired_throttle_enable_i <= 1'b1;
		pause_round(1'b0);
		pause_round(1'b1);
		@(posedge clk_i) rx_level_i <= 14'd300;
		tx_enable_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		#1 check(pause_o.req, 1'b0);
		@(posedge clk_i) rx_level_i <= 14'd0;
		tx_enable_i <= 1'b1;
		full_duplex_i <= 1'b0;
		hardwired_throttle_enable_i <= 1'b0;
		for (int i = 0; i < 32; i++) jam_run(i);
		try_no_jam(32'h0004_020F, 4'b0001, 1'b0, 1'b1);
		try_no_jam(32'h0004_020E, 4'b0100, 1'b1, 1'b1);
		try_no_jam(32'h0004_0202, 4'b0001, 1'b0, 1'b0);
		@(posedge clk_i) sys_rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		ahb(1'b0, `HMFC_CFG_ADDR, 32'h0, `HMFC_CFG_RESET);
		repeat (3) @(posedge clk_i);
		final_report();
	end
endmodule
